// *** tx_sync_defines.svh ***
// Functional notes
// - E1 even frames carry 0011011 alignment
// - odd frames: 1, alarm, five Sa bits
// - odd bit1 multiframe word, then E bits
// - even bit1 carries C1..C4 per half
// - synchronizer finds multiframe boundary only, at a fixed bit offset
// - control 3 bit 2 picks D4/ESF
// - synchronizer control register steers resync
// - latched status bit0 on sync loss
// - live loss-of-frame while hunting
// - masked latched bit drives interrupt low
// - direction bit makes sync pin output
// - io config bit0 selects multiframe pulse
// - inactive while elastic store or interleave
// - alignment uses framing pattern only
// - no signaling multiframe search
// - receive framer criteria registers held
// - out-of-sync frame count, two bytes
// - 064h..066h: E1 bytes or SLC bits
// - control 2 and SLC transmit bytes
// - control 1 picks framing bit source
// - master mode registers pick T1/E1
`ifndef TX_SYNC_DEFINES_SVH
`define TX_SYNC_DEFINES_SVH
`define A_T1_RX_CRIT     9'h014
`define A_OOS_LO         9'h054
`define A_OOS_HI         9'h055
`define A_RX_BYTE_1      9'h064
`define A_RX_BYTE_2      9'h065
`define A_RX_BYTE_3      9'h066
`define A_RX_MODE        9'h080
`define A_RX_RESYNC      9'h081
`define A_E1_RX_LOS      9'h082
`define A_RX_LS_1        9'h090
`define A_RX_LS_2        9'h091
`define A_RX_LS_4        9'h093
`define A_RX_IM_1        9'h0A0
`define A_RX_IM_2        9'h0A1
`define A_RX_IM_4        9'h0A3
`define A_TX_SLC_1       9'h164
`define A_TX_SLC_2       9'h165
`define A_TX_SLC_3       9'h166
`define A_TX_MODE        9'h180
`define A_TX_CTL_1       9'h181
`define A_TX_CTL_2       9'h182
`define A_TX_CTL_3       9'h183
`define A_TX_IO          9'h184
`define A_TX_SYNC_CTL    9'h18E
`define A_TX_LS_3        9'h192
`define A_TX_IM_3        9'h1A2
`define A_TX_BACKPLANE   9'h1F0
`define A_E1_TX_OVH      9'h1F1
`define B_FORMAT_ESF     2
`define B_MF_PULSE       0
`define B_PIN_DIR        1
`define B_WIN5           0
`define B_FORCE_RESYNC   1
`define B_SYNC_EN        2
`define B_ELASTIC        0
`define B_INTERLEAVE     1
`define B_E1_MODE        0
`define T1_FRAME_BITS    8'd193
`define D4_PATTERN       12'h8DC
`define ESF_PATTERN      6'h0B
`define E1_FAS_TAIL      7'h1B
`define E1_MF_WORD       6'h0B
`define HUNT_FRAMES      6'd24
`endif

// *** tx_sync_pkg.sv ***
package tx_sync_pkg;
  // synchronizer state, gray along off -> hunt -> locked
  typedef enum logic [1:0] {
    SYNC_OFF    = 2'b00,
    SYNC_HUNT   = 2'b01,
    SYNC_LOCKED = 2'b11
  } sync_state_t;
endpackage : tx_sync_pkg

// *** e1_framing_and_tx_frame_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tx_sync_defines.svh"
module e1_framing_and_tx_frame_sync
  import tx_sync_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        tx_bit_clk,
  input  wire logic        tx_serial_in,
  output logic             tx_frame_sync_pin_out,
  output logic             tx_frame_sync_pin_oe_n,
  output logic             loss_of_frame_live,
  output logic             interrupt_out_n,
  input  wire logic [3:0]  e1_frame_index,
  input  wire logic [3:0]  e1_crc_remainder,
  output logic      [7:0]  e1_ts0_byte,
  input  wire logic        rx_oof_frame,
  input  wire logic        rx_capture,
  input  wire logic [7:0]  rx_align_byte,
  input  wire logic [7:0]  rx_nonalign_byte,
  input  wire logic [23:0] rx_slc_bits,
  input  wire logic [7:0]  rx_status_set_1,
  input  wire logic [7:0]  rx_status_set_2,
  input  wire logic [7:0]  rx_status_set_4,
  output logic      [7:0]  rx_resync_control,
  output logic      [7:0]  t1_rx_alarm_oof_criteria,
  output logic      [7:0]  e1_rx_los_criteria,
  output logic      [7:0]  rx_master_mode,
  output logic      [7:0]  tx_master_mode,
  output logic      [7:0]  tx_control_1,
  output logic      [7:0]  tx_control_2,
  output logic      [23:0] tx_slc_bits
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // writable registers, then latched status, counter and capture
  logic [7:0]  tx_control_3;             // frame format select lives here
  logic [7:0]  tx_io_config;             // pin direction and pulse select
  logic [7:0]  tx_synchronizer_control;  // window, force resync, enable
  logic [7:0]  tx_backplane;             // elastic store and interleave
  logic [7:0]  e1_tx_overhead;           // alarm, Sa4..Sa8, E1, E2
  logic [7:0]  rx_mask [3];              // receive masks 1, 2, 4
  logic [7:0]  rx_latched [3];           // receive latched 1, 2, 4
  logic [7:0]  tx_irq_mask_3;
  logic        loss_of_frame_latched;    // latched status 3 bit 0
  logic [15:0] oos_count;                // frames out of sync
  logic [23:0] rx_link_bytes;            // captured alignment or slc bytes

  // write decode, one strobe per register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_resync_control        <= 8'h00;
      t1_rx_alarm_oof_criteria <= 8'h00;
      e1_rx_los_criteria       <= 8'h00;
      rx_master_mode           <= 8'h00;
      tx_master_mode           <= 8'h00;
      tx_control_1             <= 8'h00;
      tx_control_2             <= 8'h00;
      tx_control_3             <= 8'h00;
      tx_io_config             <= 8'h00;
      tx_synchronizer_control  <= 8'h00;
      tx_backplane             <= 8'h00;
      e1_tx_overhead           <= 8'h00;
      tx_irq_mask_3            <= 8'h00;
      tx_slc_bits              <= 24'h000000;
      for (int i = 0; i < 3; i++) rx_mask[i] <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `A_RX_RESYNC:    rx_resync_control        <= reg_wdata;
        `A_T1_RX_CRIT:   t1_rx_alarm_oof_criteria <= reg_wdata;
        `A_E1_RX_LOS:    e1_rx_los_criteria       <= reg_wdata;
        `A_RX_MODE:      rx_master_mode           <= reg_wdata;
        `A_TX_MODE:      tx_master_mode           <= reg_wdata;
        `A_TX_CTL_1:     tx_control_1             <= reg_wdata;
        `A_TX_CTL_2:     tx_control_2             <= reg_wdata;
        `A_TX_CTL_3:     tx_control_3             <= reg_wdata;
        `A_TX_IO:        tx_io_config             <= reg_wdata;
        `A_TX_SYNC_CTL:  tx_synchronizer_control  <= reg_wdata;
        `A_TX_BACKPLANE: tx_backplane             <= reg_wdata;
        `A_E1_TX_OVH:    e1_tx_overhead           <= reg_wdata;
        `A_TX_IM_3:      tx_irq_mask_3            <= reg_wdata;
        `A_TX_SLC_1:     tx_slc_bits[23:16]       <= reg_wdata;
        `A_TX_SLC_2:     tx_slc_bits[15:8]        <= reg_wdata;
        `A_TX_SLC_3:     tx_slc_bits[7:0]         <= reg_wdata;
        `A_RX_IM_1:      rx_mask[0]               <= reg_wdata;
        `A_RX_IM_2:      rx_mask[1]               <= reg_wdata;
        `A_RX_IM_4:      rx_mask[2]               <= reg_wdata;
        default: ;       // unmapped writes are dropped
      endcase
    end
  end

  // receive latched status: hardware set beats a same-cycle host clear
  logic [7:0] rx_set [3];
  assign rx_set[0] = rx_status_set_1;
  assign rx_set[1] = rx_status_set_2;
  assign rx_set[2] = rx_status_set_4;
  localparam logic [8:0] RX_LS_ADDR [3] = '{`A_RX_LS_1, `A_RX_LS_2, `A_RX_LS_4};
  for (genvar g = 0; g < 3; g++) begin : g_rx_ls
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        rx_latched[g] <= 8'h00;
      end else begin
        rx_latched[g] <= rx_set[g] |
          (rx_latched[g] & ~((reg_wr && reg_addr == RX_LS_ADDR[g]) ? reg_wdata : 8'h00));
      end
    end
  end

  // out-of-sync frame counter, saturates rather than wrapping
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oos_count <= 16'h0000;
    end else if (rx_oof_frame && oos_count != 16'hFFFF) begin
      oos_count <= oos_count + 16'h0001;
    end
  end

  // receive overhead capture, one snapshot per capture pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_link_bytes <= 24'h000000;
    end else if (rx_capture) begin
      rx_link_bytes <= rx_master_mode[`B_E1_MODE] ? {rx_align_byte, rx_nonalign_byte, 8'h00} : rx_slc_bits;
    end
  end

  // bit 1 of an odd frame: multiframe word up to frame 11, E1/E2 after
  wire odd_bit1 = (e1_frame_index[3:1] < 3'd6) ? 1'(`E1_MF_WORD >> (3'd5 - e1_frame_index[3:1]))
                                               : e1_tx_overhead[7 - e1_frame_index[1]];

  // e1 timeslot zero byte, bit 1 of the frame in bit 7
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      e1_ts0_byte <= 8'h00;
    end else if (!e1_frame_index[0]) begin
      // even frame: crc bit then alignment tail
      e1_ts0_byte <= {e1_crc_remainder[3 - {1'b0, e1_frame_index[2:1]}], `E1_FAS_TAIL};
    end else begin
      // odd frame: multiframe word or e bits, then 1, alarm, Sa
      e1_ts0_byte <= {odd_bit1, 1'b1, e1_tx_overhead[0], e1_tx_overhead[5:1]};
    end
  end

  // bit clock and data resynchronised, edge taken from the second stage on
  logic [2:0] clk_sync;
  logic [1:0] data_sync;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clk_sync  <= 3'b000;
      data_sync <= 2'b00;
    end else begin
      clk_sync  <= {clk_sync[1:0], tx_bit_clk};
      data_sync <= {data_sync[0], tx_serial_in};
    end
  end
  wire bit_strobe = clk_sync[1] & ~clk_sync[2];
  wire bit_value  = data_sync[1];

  // synchronizer runs only when enabled and both the elastic store and interleave are off
  wire sync_active = tx_synchronizer_control[`B_SYNC_EN] &
                     ~tx_backplane[`B_ELASTIC] & ~tx_backplane[`B_INTERLEAVE];
  wire esf = tx_control_3[`B_FORMAT_ESF];

  sync_state_t state;
  logic [7:0]  bit_pos;      // position within the 193-bit frame
  logic [4:0]  frame_idx;    // frame within multiframe, 0-based
  logic [23:0] f_hist;       // framing bits seen, newest in bit 0
  logic [5:0]  hunt_frames;  // frames spent on one bit alignment
  logic [4:0]  err_hist;     // recent framing check results
  logic        slip;

  // candidate history as it will look after this framing bit
  wire [23:0] hist_next = {f_hist[22:0], bit_value};
  // only framing bits count; crc and signaling bits are never checked
  wire pattern_hit = esf ? ({hist_next[20], hist_next[16], hist_next[12],
                              hist_next[8], hist_next[4], hist_next[0]} == `ESF_PATTERN)
                         : (hist_next[11:0] == `D4_PATTERN);
  wire [4:0] last_frame = esf ? 5'd23 : 5'd11;
  wire check_frame = ~esf | (frame_idx[1:0] == 2'b11);
  wire expected = esf ? 1'(`ESF_PATTERN >> (3'd5 - 3'(frame_idx[4:2])))
                      : 1'(`D4_PATTERN >> (4'd11 - frame_idx[3:0]));
  wire f_bit = bit_strobe && bit_pos == 8'd0;
  wire [4:0] errs_next = {err_hist[3:0], bit_value != expected};
  wire [4:0] win_mask = tx_synchronizer_control[`B_WIN5] ? 5'h1F : 5'h0F;
  wire [4:0] win = errs_next & win_mask;
  wire too_many = ($countones(win) >= 2);
  wire force_resync = reg_wr && reg_addr == `A_TX_SYNC_CTL && reg_wdata[`B_FORCE_RESYNC];
  wire lose = state == SYNC_LOCKED && (force_resync || (f_bit && check_frame && too_many));
  // 24 frames of tries per offset in d4; esf taps span 21 frames, so a
  // single multiframe could slip past a good offset before its pattern fills
  wire [5:0] hunt_limit = esf ? 6'((`HUNT_FRAMES << 1) - 6'd1) : `HUNT_FRAMES - 6'd1;

  // bit position counter; slip comes the cycle after a strobe, when no strobe can fall, so it never holds the count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bit_pos <= 8'd0;
    end else if (bit_strobe && !slip) begin
      bit_pos <= (bit_pos == `T1_FRAME_BITS - 8'd1) ? 8'd0 : bit_pos + 8'd1;
    end
  end

  // frame alignment state machine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state       <= SYNC_OFF;
      frame_idx   <= 5'd0;
      f_hist      <= 24'h000000;
      hunt_frames <= 6'd0;
      err_hist    <= 5'd0;
      slip        <= 1'b0;
    end else begin
      slip <= 1'b0;
      case (state)
        SYNC_OFF: begin
          // idle; start hunting once allowed to run
          // history starts clean so stale framing bits cannot fake a match
          f_hist      <= 24'h000000;
          hunt_frames <= 6'd0;
          if (sync_active) state <= SYNC_HUNT;
        end
        SYNC_HUNT: begin
          if (!sync_active) begin
            state <= SYNC_OFF;
          end else if (f_bit) begin
            f_hist <= hist_next;
            if (pattern_hit) begin
              state     <= SYNC_LOCKED;
              frame_idx <= 5'd0;
              err_hist  <= 5'd0;
            end else if (hunt_frames == hunt_limit) begin
              // no pattern at this offset: raise slip, which falls between bit strobes and leaves bit_pos unshifted
              hunt_frames <= 6'd0;
              slip        <= 1'b1;
            end else begin
              hunt_frames <= hunt_frames + 6'd1;
            end
          end
        end
        SYNC_LOCKED: begin
          if (!sync_active) begin
            state <= SYNC_OFF;
          end else if (lose) begin
            state       <= SYNC_HUNT;
            hunt_frames <= 6'd0;
            f_hist      <= 24'h000000;
          end else if (f_bit) begin
            frame_idx <= (frame_idx == last_frame) ? 5'd0 : frame_idx + 5'd1;
            if (check_frame) err_hist <= errs_next;
          end
        end
        default: state <= SYNC_OFF;
      endcase
    end
  end

  // live and latched loss-of-frame, plus interrupt
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loss_of_frame_live    <= 1'b0;
      loss_of_frame_latched <= 1'b0;
      interrupt_out_n       <= 1'b1;
    end else begin
      loss_of_frame_live <= (state == SYNC_HUNT);
      // set wins over a same-cycle write-one clear
      loss_of_frame_latched <= lose | (loss_of_frame_latched &
        ~(reg_wr && reg_addr == `A_TX_LS_3 && reg_wdata[0]));
      interrupt_out_n <= ~((loss_of_frame_latched & tx_irq_mask_3[0]) |
        (|(rx_latched[0] & rx_mask[0])) | (|(rx_latched[1] & rx_mask[1])) |
        (|(rx_latched[2] & rx_mask[2])));
    end
  end

  // sync pin: driven only with the direction bit set; pulse lasts one bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_frame_sync_pin_out  <= 1'b0;
      tx_frame_sync_pin_oe_n <= 1'b1;
    end else begin
      tx_frame_sync_pin_oe_n <= ~tx_io_config[`B_PIN_DIR];
      if (bit_strobe) begin
        tx_frame_sync_pin_out <= state == SYNC_LOCKED && bit_pos == 8'd0 &&
          (!tx_io_config[`B_MF_PULSE] || frame_idx == 5'd0);
      end
    end
  end

  // read mux, data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `A_RX_RESYNC:    reg_rdata <= rx_resync_control;
        `A_T1_RX_CRIT:   reg_rdata <= t1_rx_alarm_oof_criteria;
        `A_E1_RX_LOS:    reg_rdata <= e1_rx_los_criteria;
        `A_RX_MODE:      reg_rdata <= rx_master_mode;
        `A_TX_MODE:      reg_rdata <= tx_master_mode;
        `A_TX_CTL_1:     reg_rdata <= tx_control_1;
        `A_TX_CTL_2:     reg_rdata <= tx_control_2;
        `A_TX_CTL_3:     reg_rdata <= tx_control_3;
        `A_TX_IO:        reg_rdata <= tx_io_config;
        `A_TX_SYNC_CTL:  reg_rdata <= tx_synchronizer_control;
        `A_TX_BACKPLANE: reg_rdata <= tx_backplane;
        `A_E1_TX_OVH:    reg_rdata <= e1_tx_overhead;
        `A_TX_IM_3:      reg_rdata <= tx_irq_mask_3;
        `A_TX_LS_3:      reg_rdata <= {7'h00, loss_of_frame_latched};
        `A_TX_SLC_1:     reg_rdata <= tx_slc_bits[23:16];
        `A_TX_SLC_2:     reg_rdata <= tx_slc_bits[15:8];
        `A_TX_SLC_3:     reg_rdata <= tx_slc_bits[7:0];
        `A_OOS_LO:       reg_rdata <= oos_count[7:0];
        `A_OOS_HI:       reg_rdata <= oos_count[15:8];
        `A_RX_BYTE_1:    reg_rdata <= rx_link_bytes[23:16];
        `A_RX_BYTE_2:    reg_rdata <= rx_link_bytes[15:8];
        `A_RX_BYTE_3:    reg_rdata <= rx_link_bytes[7:0];
        `A_RX_LS_1:      reg_rdata <= rx_latched[0];
        `A_RX_LS_2:      reg_rdata <= rx_latched[1];
        `A_RX_LS_4:      reg_rdata <= rx_latched[2];
        `A_RX_IM_1:      reg_rdata <= rx_mask[0];
        `A_RX_IM_2:      reg_rdata <= rx_mask[1];
        `A_RX_IM_4:      reg_rdata <= rx_mask[2];
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks kept beside the logic
  AST_FAS_EVEN: assert property (!e1_frame_index[0] |=> e1_ts0_byte[6:0] == 7'h1B)
    else $error("alignment tail wrong in even frame");
  AST_NFAS_ODD: assert property (e1_frame_index[0] |=> e1_ts0_byte[6] && e1_ts0_byte[5] == $past(e1_tx_overhead[0]))
    else $error("odd frame fixed one or alarm wrong");
  AST_OFF_WHEN_ELASTIC: assert property (tx_backplane[`B_ELASTIC] |=> state == SYNC_OFF)
    else $error("synchronizer running with elastic store");
  AST_LIVE_FOLLOWS: assert property ((state == SYNC_HUNT) |=> loss_of_frame_live)
    else $error("live loss-of-frame missing while hunting");
  AST_LATCH_ON_LOSS: assert property (lose |=> loss_of_frame_latched ##1 loss_of_frame_latched)
    else $error("latched loss not held after sync loss");
  AST_LATCH_HOLDS: assert property (loss_of_frame_latched && !(reg_wr && reg_addr == `A_TX_LS_3)
    |=> loss_of_frame_latched)
    else $error("latched bit dropped without a clear");
  AST_IRQ: assert property (loss_of_frame_latched && tx_irq_mask_3[0] |=> !interrupt_out_n)
    else $error("interrupt not asserted for masked-in loss");
  AST_PIN_DIR: assert property (tx_io_config[`B_PIN_DIR] |=> !tx_frame_sync_pin_oe_n)
    else $error("sync pin not driven with direction set");
  AST_MF_PULSE: assert property (tx_frame_sync_pin_out && tx_io_config[`B_MF_PULSE] && $stable(tx_io_config)
    |-> $past(frame_idx == 5'd0 || !bit_strobe))
    else $error("multiframe pulse outside frame zero");
  AST_COUNT: assert property (rx_oof_frame && oos_count < 16'h00FF |=> oos_count == $past(oos_count) + 16'h0001)
    else $error("out-of-sync count did not step");
  // release, idle, forced and receive interrupt paths
  AST_LIVE_CLEAR: assert property (state != SYNC_HUNT |=> !loss_of_frame_live)
    else $error("live loss-of-frame set while not hunting");
  AST_PIN_RELEASE: assert property (!tx_io_config[`B_PIN_DIR] |=> tx_frame_sync_pin_oe_n)
    else $error("sync pin driven with direction clear");
  AST_NO_PULSE_UNLOCKED: assert property (bit_strobe && state != SYNC_LOCKED |=> !tx_frame_sync_pin_out)
    else $error("sync pulse while not locked");
  AST_FORCE_RESYNC: assert property (force_resync && state == SYNC_LOCKED |=> state == SYNC_HUNT)
    else $error("forced resync did not restart the hunt");
  AST_RX_IRQ: assert property ((|(rx_latched[0] & rx_mask[0])) |=> !interrupt_out_n)
    else $error("interrupt not asserted for masked-in receive status");
endmodule : e1_framing_and_tx_frame_sync
`default_nettype wire

// *** bp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// backplane source: 193-bit frames, framing bit first, 5 mclk per bit
module bp_model (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic esf,
  input  wire logic corrupt,
  output var  logic bclk,
  output var  logic sdata
);
  localparam logic [11:0] D4_PAT  = 12'h8DC; // frames 1..12, first frame is msb
  localparam logic [5:0]  ESF_PAT = 6'h0B;   // every fourth frame
  logic [2:0] cnt;  // mclk phase within a bit
  logic [7:0] bpos; // bit within frame
  logic [4:0] fr;   // frame within multiframe
  logic       fbit; // framing bit of this frame
  initial {bclk, sdata} = 2'b00;
  // other esf framing bits held at 1 so no wrong phase can match
  always_comb begin
    if (esf) begin
      fbit = (fr[1:0] == 2'h3) ? ESF_PAT[5 - fr[4:2]] : 1'b1;
    end else begin
      fbit = D4_PAT[11 - fr];
    end
  end
  // clock stands low between runs; idle data toggles so no stale level shows
  always @(posedge mclk) begin
    if (!run) begin
      {cnt, bpos, fr} <= '0;
      bclk <= 1'b0;
      sdata <= ~sdata;
    end else begin
      cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      bclk <= (cnt == 3'h1) || (cnt == 3'h2);
      // payload is the same every frame, so only the framing bit can match
      if (cnt == 3'h0) begin
        sdata <= (bpos == 8'h00) ? fbit ^ corrupt : bpos[0];
      end
      if (cnt == 3'h4) begin
        bpos <= (bpos == 8'hC0) ? 8'h00 : bpos + 8'h01;
        if (bpos == 8'hC0) begin
          fr <= (fr == (esf ? 5'h17 : 5'h0B)) ? 5'h00 : fr + 5'h01;
        end
      end
    end
  end
endmodule : bp_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import tx_sync_pkg::*;;
  logic        mclk, rst_n, reg_wr, reg_rd, rx_oof_frame, rx_capture, run, esf, corrupt;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, e1_ts0_byte, rx_align_byte, rx_nonalign_byte;
  logic        tx_bit_clk, tx_serial_in, tx_frame_sync_pin_out, tx_frame_sync_pin_oe_n;
  logic        loss_of_frame_live, interrupt_out_n;
  logic [3:0]  e1_frame_index, e1_crc_remainder;
  logic [23:0] rx_slc_bits, tx_slc_bits;
  logic [7:0]  stat_set [3];
  logic [7:0]  rx_resync_control, t1_rx_alarm_oof_criteria, e1_rx_los_criteria, rx_master_mode;
  logic [7:0]  tx_master_mode, tx_control_1, tx_control_2;
  int          n_mismatch, comparisons;
  e1_framing_and_tx_frame_sync u_dut (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_bit_clk, .tx_serial_in,
    .tx_frame_sync_pin_out, .tx_frame_sync_pin_oe_n, .loss_of_frame_live, .interrupt_out_n,
    .e1_frame_index, .e1_crc_remainder, .e1_ts0_byte, .rx_oof_frame, .rx_capture, .rx_align_byte,
    .rx_nonalign_byte, .rx_slc_bits, .rx_status_set_1(stat_set[0]), .rx_status_set_2(stat_set[1]),
    .rx_status_set_4(stat_set[2]), .rx_resync_control, .t1_rx_alarm_oof_criteria, .e1_rx_los_criteria,
    .rx_master_mode, .tx_master_mode, .tx_control_1, .tx_control_2, .tx_slc_bits);
  bp_model u_bp (.mclk, .run, .esf, .corrupt, .bclk(tx_bit_clk), .sdata(tx_serial_in));
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobes, a free cycle after each
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the read edge
  task automatic rd_chk(input string what, input logic [8:0] a, input logic [7:0] exp);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(what, 24'(exp), 24'(reg_rdata));
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask : settle
  // bounded wait on the live flag; running out ends the run
  task automatic wait_lof(input logic v, input int bound);
    int i;
    for (i = 0; i < bound && loss_of_frame_live !== v; i++) @(posedge mclk);
    chk("lof", 24'(v), 24'(loss_of_frame_live));
    if (i == bound) stop_test();
  endtask : wait_lof
  task automatic pulses(input int cyc, input int exp);
    int n;
    logic prev;
    n = 0;
    prev = tx_frame_sync_pin_out;
    repeat (cyc) begin
      @(posedge mclk);
      if (tx_frame_sync_pin_out === 1'b1 && prev !== 1'b1) n++;
      prev = tx_frame_sync_pin_out;
    end
    chk("sync pulses", 24'(exp), 24'(n));
  endtask : pulses
  task automatic t_regs();
    logic [8:0] ad [10] = '{9'h014, 9'h080, 9'h081, 9'h082, 9'h180, 9'h181, 9'h182, 9'h164, 9'h165, 9'h166};
    logic [7:0] port [7];
    for (int i = 0; i < 10; i++) rd_chk("reset value", ad[i], 8'h00);
    for (int i = 0; i < 10; i++) wr(ad[i], 8'h30 + 8'(i));
    for (int i = 0; i < 10; i++) rd_chk("readback", ad[i], 8'h30 + 8'(i));
    port = '{t1_rx_alarm_oof_criteria, rx_master_mode, rx_resync_control, e1_rx_los_criteria,
             tx_master_mode, tx_control_1, tx_control_2};
    for (int i = 0; i < 7; i++) chk("register port", 24'(8'h30 + 8'(i)), 24'(port[i]));
    chk("slc port", 24'h373839, tx_slc_bits);
    wr(9'h1FF, 8'hFF);
    rd_chk("unmapped", 9'h1FF, 8'h00);
  endtask : t_regs
  // 300 one-cycle pulses carry into the high byte
  task automatic t_count();
    repeat (600) begin
      @(posedge mclk);
      rx_oof_frame <= ~rx_oof_frame;
    end
    rd_chk("count lo", 9'h054, 8'h2C);
    rd_chk("count hi", 9'h055, 8'h01);
  endtask : t_count
  // one snapshot per mode; inputs change after it, so a live path shows up
  task automatic t_capture();
    for (int m = 1; m >= 0; m--) begin
      wr(9'h080, 8'(m));
      @(posedge mclk);
      {rx_align_byte, rx_nonalign_byte, rx_slc_bits, rx_capture} <= {8'h9B, 8'h5F, 24'hC3A55A, 1'b1};
      @(posedge mclk);
      {rx_align_byte, rx_nonalign_byte, rx_slc_bits, rx_capture} <= '0;
      if (m == 1) begin
        rd_chk("align", 9'h064, 8'h9B);
        rd_chk("nonalign", 9'h065, 8'h5F);
        rd_chk("e1 third", 9'h066, 8'h00);
      end else begin
        rd_chk("slc 1", 9'h064, 8'hC3);
        rd_chk("slc 2", 9'h065, 8'hA5);
        rd_chk("slc 3", 9'h066, 8'h5A);
      end
    end
  endtask : t_capture
  task automatic t_e1();
    logic [7:0] ovh = 8'hA5;
    logic [5:0] mf = 6'h0B;
    logic [3:0] crc = 4'hA;
    logic [7:0] exp;
    wr(9'h1F1, ovh);
    for (int f = 0; f < 16; f++) begin
      @(posedge mclk);
      {e1_frame_index, e1_crc_remainder} <= {4'(f), crc};
      if (f % 2 == 0) exp = {crc[3 - (f / 2) % 4], 7'h1B};
      else exp = {(f == 13) ? ovh[7] : (f == 15) ? ovh[6] : mf[5 - f / 2], 1'b1, ovh[0], ovh[5:1]};
      @(posedge mclk);
      #1 chk("frame byte", 24'(exp), 24'(e1_ts0_byte));
    end
  endtask : t_e1
  task automatic t_rx_irq();
    logic [8:0] st [3] = '{9'h090, 9'h091, 9'h093};
    logic [8:0] mk [3] = '{9'h0A0, 9'h0A1, 9'h0A3};
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      stat_set[k] <= 8'h24;
      @(posedge mclk);
      stat_set[k] <= 8'h00;
      rd_chk("rx latched", st[k], 8'h24);
      chk("irq unmasked", 24'h1, 24'(interrupt_out_n));
      wr(mk[k], 8'h04);
      settle();
      chk("irq masked", 24'h0, 24'(interrupt_out_n));
      wr(st[k], 8'h04);
      rd_chk("rx one cleared", st[k], 8'h20);
      settle();
      chk("irq cleared", 24'h1, 24'(interrupt_out_n));
      wr(st[k], 8'h20);
    end
  endtask : t_rx_irq
  // d4 lock; 965 mclk per frame
  task automatic t_d4();
    wr(9'h1A2, 8'h01);
    wr(9'h184, 8'h02);
    wr(9'h18E, 8'h04);
    @(posedge mclk);
    run <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("pin drive", 24'h0, 24'(tx_frame_sync_pin_oe_n));
    chk("hunting", 24'h1, 24'(loss_of_frame_live));
    wait_lof(1'b0, 30000);
    pulses(3860, 4);
    wr(9'h184, 8'h03);
    pulses(11580, 1);
  endtask : t_d4
  task automatic t_loss();
    @(posedge mclk);
    corrupt <= 1'b1;
    wait_lof(1'b1, 5000);
    corrupt <= 1'b0;
    settle();
    chk("irq on loss", 24'h0, 24'(interrupt_out_n));
    rd_chk("loss latched", 9'h192, 8'h01);
    wr(9'h192, 8'h01);
    settle();
    rd_chk("loss cleared", 9'h192, 8'h00);
    chk("irq released", 24'h1, 24'(interrupt_out_n));
  endtask : t_loss
  task automatic t_off();
    for (int m = 1; m < 3; m++) begin
      wr(9'h1F0, 8'(m));
      settle();
      chk("lof when off", 24'h0, 24'(loss_of_frame_live));
      pulses(2000, 0);
    end
    wr(9'h1F0, 8'h00);
  endtask : t_off
  // the line keeps running, so the bit position stays on the framing bit
  task automatic t_esf();
    wr(9'h18E, 8'h00);
    wr(9'h183, 8'h04);
    wr(9'h184, 8'h02);
    esf <= 1'b1;
    wr(9'h18E, 8'h04);
    wait_lof(1'b1, 8);
    wait_lof(1'b0, 60000);
    pulses(3860, 4);
    wr(9'h18E, 8'h06);
    settle();
    chk("forced resync", 24'h1, 24'(loss_of_frame_live));
  endtask : t_esf
  initial begin
    {rst_n, reg_wr, reg_rd, rx_oof_frame, rx_capture, run, esf, corrupt} = '0;
    {reg_addr, reg_wdata, e1_frame_index, e1_crc_remainder} = '0;
    {rx_align_byte, rx_nonalign_byte, rx_slc_bits} = '0;
    stat_set = '{3{8'h00}};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_count();
    t_capture();
    t_e1();
    t_rx_irq();
    t_d4();
    t_loss();
    t_off();
    t_esf();
    stop_test();
  end
endmodule : tb
`default_nettype wire
